// File: src/sgd_pkg.sv
package sgd_pkg;

   // Core clock rate used to turn times into cycle counts.
   localparam int CLK_MHZ = 100;

   // One inserted wait state lasts one host clock period.
   localparam int WAIT_NS = 280;
   localparam int WAIT_CYC = (WAIT_NS * CLK_MHZ + 999) / 1000;
   localparam int WAIT_CNT_W = 6;

   // Row strobe to address switch, and address switch to column strobe.
   localparam int ROW_TO_MUX_NS = 20;
   localparam int ROW_TO_MUX_CYC = (ROW_TO_MUX_NS * CLK_MHZ + 999) / 1000;
   localparam int MUX_TO_COL_NS = 20;
   localparam int MUX_TO_COL_CYC = (MUX_TO_COL_NS * CLK_MHZ + 999) / 1000;
   localparam int DRAM_CNT_W = 4;

   // Positions of the two page bits inside the reduced host address.
   localparam int ADDR_A15_POS = 8;
   localparam int ADDR_A14_POS = 7;

   // Memory pages of 16 KB each, and slot numbers.
   localparam logic [1:0] PAGE_1 = 2'h1;
   localparam logic [1:0] PAGE_2 = 2'h2;
   localparam logic [1:0] PAGE_3 = 2'h3;
   localparam logic [1:0] SLOT_0 = 2'h0;
   localparam logic [1:0] SLOT_1 = 2'h1;
   localparam logic [1:0] SLOT_2 = 2'h2;
   localparam logic [1:0] SLOT_3 = 2'h3;
   localparam logic [1:0] SUBSLOT_RAM = 2'h2;

   // Keyboard matrix shape and the strap bit caught after reset.
   localparam int KBD_ROWS = 10;
   localparam int KBD_COLS = 8;
   localparam int FUNC_SEL_BIT = 6;
   // Three edges: the pin reaches stage two only after the second edge.
   localparam logic [1:0] FUNC_CAPTURE_DLY = 2'h3;
   localparam int JOY_PORTS = 2;

   // Host bus pins, all active low except the address.
   typedef struct packed {
      logic [8:0] addr;
      logic mreq_n;
      logic rd_n;
      logic wr_n;
      logic m1_n;
      logic rfsh_n;
   } sgd_host_bus_t;

   // Joystick port pins as read, all pulled up and active low.
   typedef struct packed {
      logic up_n;
      logic down_n;
      logic left_n;
      logic right_n;
      logic button1_n;
      logic button2_n;
   } sgd_joy_t;

   // Reset values of the synchronisers: idle bus, released pins.
   localparam sgd_host_bus_t HOST_IDLE = 14'h3FFF;
   localparam sgd_joy_t JOY_IDLE = 6'h3F;
   localparam logic [7:0] KBD_COL_IDLE = 8'hFF;

   typedef enum logic [2:0] {
      DR_IDLE,
      DR_ROW,
      DR_MUX,
      DR_COL,
      DR_RFSH
   } sgd_dram_state_t;

endpackage

// File: src/sgd_glue.sv
// Functional notes
// - Hold the wait request for exactly one wait state per opcode fetch.
// - Wait request is open drain, only ever pulling low.
// - Row strobe pulses on refresh cycles, giving row-only refresh.
// - Address mux switches row to column between row and column strobes.
// - Column strobe A for slot 0, addresses C000 to FFFF.
// - Column strobe B for expanded slot 3-2, whole 0000 to FFFF range.
// - DRAM write enable during memory writes to DRAM.
// - Select the built-in BASIC ROM when it is addressed.
// - First ROM page select for 4000 through 7FFF.
// - Second ROM page select for 8000 through BFFF.
// - Combined ROM select for 4000 through BFFF.
// - Separate selects for primary slots 1, 2 and 3.
// - Read four pulled-up direction inputs per joystick port.
// - Open-drain trigger lines readable back, plus one strobe per port.
// - Ten open-drain row scan outputs, eight pulled-up column inputs.
// - Column bit 6 is caught at reset as a function select.
// - Read layout input, drive two open-drain lamp outputs.
// - Drive printer data and strobe, read pulled-up busy input.
// - Decode from only nine host address lines.
`timescale 1ns/1ps
`default_nettype none

module sgd_glue (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire sgd_pkg::sgd_host_bus_t host_i,
   input wire logic [7:0] slot_map_i,
   input wire logic [7:0] subslot_map_i,
   output logic wait_req_o,
   output logic wait_req_oe_o,
   output logic ram_row_strobe_n_o,
   output logic dram_addr_mux_o,
   output logic dram_col_strobe_a_n_o,
   output logic dram_col_strobe_b_n_o,
   output logic dram_write_en_n_o,
   output logic basic_rom_sel_n_o,
   output logic rom_page1_sel_n_o,
   output logic rom_page2_sel_n_o,
   output logic rom_both_pages_sel_n_o,
   output logic slot1_sel_n_o,
   output logic slot2_sel_n_o,
   output logic slot3_sel_n_o,
   input wire sgd_pkg::sgd_joy_t joy_a_i,
   input wire sgd_pkg::sgd_joy_t joy_b_i,
   input wire logic [1:0] joy_a_button_drive_i,
   input wire logic [1:0] joy_b_button_drive_i,
   input wire logic joy_a_pulse_i,
   input wire logic joy_b_pulse_i,
   output sgd_pkg::sgd_joy_t joy_a_o,
   output sgd_pkg::sgd_joy_t joy_b_o,
   output logic [1:0] joy_a_button_o,
   output logic [1:0] joy_a_button_oe_o,
   output logic [1:0] joy_b_button_o,
   output logic [1:0] joy_b_button_oe_o,
   output logic joy_a_pulse_out_o,
   output logic joy_b_pulse_out_o,
   input wire logic [3:0] kbd_row_sel_i,
   output logic [9:0] kbd_row_scan_n_o,
   output logic [9:0] kbd_row_scan_oe_o,
   input wire logic [7:0] kbd_column_in_n_i,
   output logic [7:0] kbd_column_n_o,
   output logic kbd_func_sel_o,
   input wire logic kbd_layout_sel_i,
   output logic kbd_layout_sel_o,
   input wire logic capslock_lamp_i,
   input wire logic code_lamp_i,
   output logic capslock_lamp_n_o,
   output logic capslock_lamp_oe_o,
   output logic code_lamp_n_o,
   output logic code_lamp_oe_o,
   input wire logic [7:0] printer_data_i,
   input wire logic printer_strobe_i,
   input wire logic printer_busy_n_i,
   output logic [7:0] printer_data_out_o,
   output logic printer_strobe_n_o,
   output logic printer_busy_o
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers. Stage one is read only by stage two.

   sgd_pkg::sgd_host_bus_t host_s1_r, host_s2_r;
   sgd_pkg::sgd_joy_t joy_s1_r [2];
   sgd_pkg::sgd_joy_t joy_s2_r [2];
   logic [7:0] col_s1_r, col_s2_r;
   logic [1:0] misc_s1_r, misc_s2_r;
   logic m1_prev_r;

   // Host bus and keyboard pins, reset to their released level.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         host_s1_r <= sgd_pkg::HOST_IDLE;
         host_s2_r <= sgd_pkg::HOST_IDLE;
         m1_prev_r <= 1'b1;
         col_s1_r <= sgd_pkg::KBD_COL_IDLE;
         col_s2_r <= sgd_pkg::KBD_COL_IDLE;
         misc_s1_r <= 2'h3;
         misc_s2_r <= 2'h3;
      end else if (ce_i) begin
         host_s1_r <= host_i;
         host_s2_r <= host_s1_r;
         m1_prev_r <= host_s2_r.m1_n;
         col_s1_r <= kbd_column_in_n_i;
         col_s2_r <= col_s1_r;
         misc_s1_r <= {kbd_layout_sel_i, printer_busy_n_i};
         misc_s2_r <= misc_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode on the synchronised bus.

   logic [1:0] page, slot, subslot;
   logic mem_cyc, rfsh_cyc, hit_a, hit_b;

   // Only A15 and A14 matter for memory; the slot maps come from logic.
   always_comb begin
      page = {host_s2_r.addr[sgd_pkg::ADDR_A15_POS],
              host_s2_r.addr[sgd_pkg::ADDR_A14_POS]};
      slot = slot_map_i[{page, 1'b0} +: 2];
      subslot = subslot_map_i[{page, 1'b0} +: 2];
      mem_cyc = !host_s2_r.mreq_n && host_s2_r.rfsh_n;
      rfsh_cyc = !host_s2_r.mreq_n && !host_s2_r.rfsh_n;
      hit_a = (slot == sgd_pkg::SLOT_0) && (page == sgd_pkg::PAGE_3);
      hit_b = (slot == sgd_pkg::SLOT_3) &&
              (subslot == sgd_pkg::SUBSLOT_RAM);
   end

   // Registered selects; a refresh cycle blanks them all.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         basic_rom_sel_n_o <= 1'b1;
         rom_page1_sel_n_o <= 1'b1;
         rom_page2_sel_n_o <= 1'b1;
         rom_both_pages_sel_n_o <= 1'b1;
         slot1_sel_n_o <= 1'b1;
         slot2_sel_n_o <= 1'b1;
         slot3_sel_n_o <= 1'b1;
      end else if (ce_i) begin
         basic_rom_sel_n_o <= !(mem_cyc && slot == sgd_pkg::SLOT_0 &&
                                !page[1]);
         rom_page1_sel_n_o <= !(mem_cyc && page == sgd_pkg::PAGE_1);
         rom_page2_sel_n_o <= !(mem_cyc && page == sgd_pkg::PAGE_2);
         rom_both_pages_sel_n_o <= !(mem_cyc && page[1] != page[0]);
         slot1_sel_n_o <= !(mem_cyc && slot == sgd_pkg::SLOT_1);
         slot2_sel_n_o <= !(mem_cyc && slot == sgd_pkg::SLOT_2);
         slot3_sel_n_o <= !(mem_cyc && slot == sgd_pkg::SLOT_3);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch wait. The count is fixed, so a slow host clock sees a short one.

   logic fetch_start;
   logic [sgd_pkg::WAIT_CNT_W-1:0] wait_cnt_r;

   assign fetch_start = !host_s2_r.m1_n && m1_prev_r && !host_s2_r.mreq_n;

   // Pull the wait line low for one host period from the fetch start.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         wait_cnt_r <= '0;
         wait_req_oe_o <= 1'b0;
         wait_req_o <= 1'b0;
      end else if (ce_i) begin
         wait_req_o <= 1'b0;
         if (fetch_start) begin
            wait_cnt_r <= sgd_pkg::WAIT_CNT_W'(sgd_pkg::WAIT_CYC);
            wait_req_oe_o <= 1'b1;
         end else if (wait_cnt_r > 6'h01) begin
            wait_cnt_r <= wait_cnt_r - 6'h01;
         end else begin
            wait_cnt_r <= '0;
            wait_req_oe_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // DRAM strobe sequencer: row, address switch, column, or row only.

   sgd_pkg::sgd_dram_state_t dram_state_r, dram_state_nxt;
   logic [sgd_pkg::DRAM_CNT_W-1:0] dram_cnt_r, dram_cnt_nxt;
   logic col_a_sel_r, col_b_sel_r;
   localparam logic [3:0] ROW_LAST = 4'(sgd_pkg::ROW_TO_MUX_CYC - 1);
   localparam logic [3:0] MUX_LAST = 4'(sgd_pkg::MUX_TO_COL_CYC - 1);

   // Next state; the end of the memory request always returns to idle.
   always_comb begin
      dram_state_nxt = dram_state_r;
      dram_cnt_nxt = dram_cnt_r + 4'h1;
      unique case (dram_state_r)
         sgd_pkg::DR_IDLE: begin
            dram_cnt_nxt = '0;
            if (rfsh_cyc) begin
               dram_state_nxt = sgd_pkg::DR_RFSH;
            end else if (mem_cyc && (hit_a || hit_b)) begin
               dram_state_nxt = sgd_pkg::DR_ROW;
            end
         end
         sgd_pkg::DR_ROW: begin
            if (dram_cnt_r == ROW_LAST) begin
               dram_state_nxt = sgd_pkg::DR_MUX;
               dram_cnt_nxt = '0;
            end
         end
         sgd_pkg::DR_MUX: begin
            if (dram_cnt_r == MUX_LAST) begin
               dram_state_nxt = sgd_pkg::DR_COL;
            end
         end
         sgd_pkg::DR_COL, sgd_pkg::DR_RFSH: begin
            dram_cnt_nxt = '0;
         end
      endcase
      if (host_s2_r.mreq_n) begin
         dram_state_nxt = sgd_pkg::DR_IDLE;
      end
   end

   // State, count and which column strobe this access uses.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         dram_state_r <= sgd_pkg::DR_IDLE;
         dram_cnt_r <= '0;
         col_a_sel_r <= 1'b0;
         col_b_sel_r <= 1'b0;
      end else if (ce_i) begin
         dram_state_r <= dram_state_nxt;
         dram_cnt_r <= dram_cnt_nxt;
         if (dram_state_r == sgd_pkg::DR_IDLE) begin
            col_a_sel_r <= hit_a;
            col_b_sel_r <= hit_b && !hit_a;
         end
      end
   end

   // Strobes come from the next state so each pin is a single flop.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ram_row_strobe_n_o <= 1'b1;
         dram_addr_mux_o <= 1'b0;
         dram_col_strobe_a_n_o <= 1'b1;
         dram_col_strobe_b_n_o <= 1'b1;
         dram_write_en_n_o <= 1'b1;
      end else if (ce_i) begin
         ram_row_strobe_n_o <= dram_state_nxt == sgd_pkg::DR_IDLE;
         dram_addr_mux_o <= dram_state_nxt == sgd_pkg::DR_MUX ||
                            dram_state_nxt == sgd_pkg::DR_COL;
         dram_col_strobe_a_n_o <= !(dram_state_nxt == sgd_pkg::DR_COL &&
                                    col_a_sel_r);
         dram_col_strobe_b_n_o <= !(dram_state_nxt == sgd_pkg::DR_COL &&
                                    col_b_sel_r);
         dram_write_en_n_o <= !(dram_state_nxt == sgd_pkg::DR_COL &&
                                !host_s2_r.wr_n);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Joystick ports, one copy per port.

   sgd_pkg::sgd_joy_t joy_pin [2];
   logic [1:0] joy_drive [2];
   logic [1:0] joy_btn_oe_r [2];
   logic joy_pulse [2];
   logic joy_pulse_r [2];

   assign joy_pin[0] = joy_a_i;
   assign joy_pin[1] = joy_b_i;
   assign joy_drive[0] = joy_a_button_drive_i;
   assign joy_drive[1] = joy_b_button_drive_i;
   assign joy_pulse[0] = joy_a_pulse_i;
   assign joy_pulse[1] = joy_b_pulse_i;

   // Buttons read back the pin level, so our own pull-down shows too.
   for (genvar p = 0; p < sgd_pkg::JOY_PORTS; p++) begin : g_joy
      always_ff @(posedge core_clk_i) begin
         if (reset_i) begin
            joy_s1_r[p] <= sgd_pkg::JOY_IDLE;
            joy_s2_r[p] <= sgd_pkg::JOY_IDLE;
            joy_btn_oe_r[p] <= 2'h0;
            joy_pulse_r[p] <= 1'b0;
         end else if (ce_i) begin
            joy_s1_r[p] <= joy_pin[p];
            joy_s2_r[p] <= joy_s1_r[p];
            joy_btn_oe_r[p] <= joy_drive[p];
            joy_pulse_r[p] <= joy_pulse[p];
         end
      end
   end

   assign joy_a_o = joy_s2_r[0];
   assign joy_b_o = joy_s2_r[1];
   assign joy_a_button_oe_o = joy_btn_oe_r[0];
   assign joy_b_button_oe_o = joy_btn_oe_r[1];
   assign joy_a_pulse_out_o = joy_pulse_r[0];
   assign joy_b_pulse_out_o = joy_pulse_r[1];

   ////////////////////////////////////////////////////////////////////////
   // Keyboard, lamps and printer.

   logic [1:0] func_pend_r;

   // One row pulled low at a time; an out-of-range select scans none.
   for (genvar r = 0; r < sgd_pkg::KBD_ROWS; r++) begin : g_row
      always_ff @(posedge core_clk_i) begin
         if (reset_i) begin
            kbd_row_scan_oe_o[r] <= 1'b0;
         end else if (ce_i) begin
            kbd_row_scan_oe_o[r] <= kbd_row_sel_i == 4'(r);
         end
      end
   end

   // The strap is caught once the synchroniser has refilled after reset.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         func_pend_r <= sgd_pkg::FUNC_CAPTURE_DLY;
         kbd_func_sel_o <= 1'b1;
      end else if (ce_i && func_pend_r != 2'h0) begin
         func_pend_r <= func_pend_r - 2'h1;
         if (func_pend_r == 2'h1) begin
            kbd_func_sel_o <= col_s2_r[sgd_pkg::FUNC_SEL_BIT];
         end
      end
   end

   // Open-drain levels are always low; only the enables move.
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         kbd_row_scan_n_o <= '0;
         joy_a_button_o <= '0;
         joy_b_button_o <= '0;
         kbd_column_n_o <= sgd_pkg::KBD_COL_IDLE;
         kbd_layout_sel_o <= 1'b1;
         capslock_lamp_n_o <= 1'b0;
         capslock_lamp_oe_o <= 1'b0;
         code_lamp_n_o <= 1'b0;
         code_lamp_oe_o <= 1'b0;
         printer_data_out_o <= '0;
         printer_strobe_n_o <= 1'b1;
         printer_busy_o <= 1'b0;
      end else if (ce_i) begin
         kbd_column_n_o <= col_s2_r;
         kbd_layout_sel_o <= misc_s2_r[1];
         capslock_lamp_oe_o <= capslock_lamp_i;
         code_lamp_oe_o <= code_lamp_i;
         printer_data_out_o <= printer_data_i;
         printer_strobe_n_o <= !printer_strobe_i;
         printer_busy_o <= !misc_s2_r[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   localparam int WAIT_CHK = sgd_pkg::WAIT_CYC;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i || !ce_i);

   chk_wait_length: assert property (
      $rose(wait_req_oe_o) |->
      (wait_req_oe_o throughout ##(WAIT_CHK - 1) 1'b1) ##1 !wait_req_oe_o)
      else $error("wait request length wrong");
   chk_wait_cause: assert property (
      $rose(wait_req_oe_o) |-> $past(fetch_start))
      else $error("wait request without fetch");
   chk_wait_od: assert property (
      wait_req_oe_o |-> !wait_req_o)
      else $error("wait line driven high");
   chk_refresh_row: assert property (
      (dram_state_r == sgd_pkg::DR_IDLE && rfsh_cyc) |=>
      (!ram_row_strobe_n_o && dram_col_strobe_a_n_o && dram_col_strobe_b_n_o))
      else $error("refresh not row only");
   chk_mux_order: assert property (
      ($fell(dram_col_strobe_a_n_o) || $fell(dram_col_strobe_b_n_o)) |->
      (dram_addr_mux_o && !ram_row_strobe_n_o && $past(dram_addr_mux_o)))
      else $error("column strobe before mux");
   chk_col_a_map: assert property (
      $fell(dram_col_strobe_a_n_o) |-> col_a_sel_r && dram_col_strobe_b_n_o)
      else $error("column A outside its slot");
   chk_col_b_map: assert property (
      $fell(dram_col_strobe_b_n_o) |-> col_b_sel_r)
      else $error("column B outside its slot");
   chk_write_enable: assert property (
      !dram_write_en_n_o |-> $past(!host_s2_r.wr_n))
      else $error("write enable without write");
   chk_page1_sel: assert property (
      (mem_cyc && page == sgd_pkg::PAGE_1) |=>
      (!rom_page1_sel_n_o && !rom_both_pages_sel_n_o && rom_page2_sel_n_o))
      else $error("page one select wrong");
   chk_page2_sel: assert property (
      (mem_cyc && page == sgd_pkg::PAGE_2) |=> !rom_page2_sel_n_o)
      else $error("page two select wrong");
   chk_both_pages: assert property (
      rom_both_pages_sel_n_o == (rom_page1_sel_n_o && rom_page2_sel_n_o))
      else $error("combined select mismatch");
   chk_refresh_quiet: assert property (
      !host_s2_r.rfsh_n |=> (slot1_sel_n_o && slot2_sel_n_o &&
      slot3_sel_n_o && basic_rom_sel_n_o && rom_both_pages_sel_n_o))
      else $error("select during refresh");
   chk_row_onehot: assert property (
      $onehot0(kbd_row_scan_oe_o))
      else $error("more than one row driven");
   chk_strap_hold: assert property (
      (func_pend_r == 2'h0 && $past(func_pend_r) == 2'h0) |->
      $stable(kbd_func_sel_o))
      else $error("function select moved");

   cov_fetch_wait: cover property ($rose(wait_req_oe_o));
   cov_refresh: cover property (dram_state_r == sgd_pkg::DR_RFSH);
   cov_col_a: cover property ($fell(dram_col_strobe_a_n_o));
   cov_col_b_write: cover property (!dram_col_strobe_b_n_o &&
                                    !dram_write_en_n_o);

endmodule

`default_nettype wire

// File: testbench/sgd_far_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Far side of the glue: the host bus master and the pulled-up pins.
module sgd_far_model (
   input wire logic core_clk_i,
   input wire logic [1:0] btn_oe_a_i,
   input wire logic [1:0] btn_oe_b_i,
   input wire logic [1:0] btn_ext_a_i,
   input wire logic [1:0] btn_ext_b_i,
   input wire logic [7:0] dir_i,
   input wire logic busy_i,
   output var sgd_pkg::sgd_host_bus_t host_o,
   output sgd_pkg::sgd_joy_t joy_a_o,
   output sgd_pkg::sgd_joy_t joy_b_o,
   output logic busy_n_o
);

   // A button line is low when either party pulls it, else pulled up.
   assign joy_a_o = {dir_i[7:4], ~(btn_oe_a_i | btn_ext_a_i)};
   assign joy_b_o = {dir_i[3:0], ~(btn_oe_b_i | btn_ext_b_i)};
   // The printer pulls the line low when busy; the pull-up reads ready.
   assign busy_n_o = ~busy_i;

   // Strobes idle high so no cycle is seen before the first start.
   initial host_o = sgd_pkg::HOST_IDLE;

   // Opens a cycle just after an edge and holds it until finish.
   task automatic start(input logic [8:0] a, input logic fetch,
                        input logic wr, input logic rf);
      @(posedge core_clk_i);
      #1;
      host_o.addr = a;
      host_o.mreq_n = 1'b0;
      host_o.rd_n = wr | rf;
      host_o.wr_n = ~wr;
      host_o.m1_n = ~fetch;
      host_o.rfsh_n = ~rf;
   endtask

   // Released address lines show garbage, never the last value.
   task automatic finish();
      @(posedge core_clk_i);
      #1;
      host_o.mreq_n = 1'b1;
      host_o.rd_n = 1'b1;
      host_o.wr_n = 1'b1;
      host_o.m1_n = 1'b1;
      host_o.rfsh_n = 1'b1;
      host_o.addr = ~host_o.addr;
   endtask

endmodule
`default_nettype wire

// File: testbench/test_system_glue_decode_io.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module test_system_glue_decode_io;

   logic clk, rst, ce, pa, pb, lamp_c, lamp_k, layout, printer_strobe_n, busy;
   logic [7:0] smap, ssub, kcol, pdata, dirs;
   logic [1:0] bda, bdb, exa, exb;
   logic [3:0] rsel;
   logic [31:0] seed = 32'h6617BF4A;
   int failures = 0;
   int n_checks = 0;
   sgd_pkg::sgd_host_bus_t host;
   sgd_pkg::sgd_joy_t ja, jb, pin_a, pin_b;
   logic wait_q, wait_oe, row_n, mux, cola, colb, we_n, brom, p1, p2, p12;
   logic s1, s2, s3, pao, pbo, fsel, lay_o, cl_n, cl_oe, cd_n, cd_oe;
   logic printer_strobe_n_n, busy_o, busy_n;
   logic [1:0] bo_a, boe_a, bo_b, boe_b;
   logic [9:0] rs_n, rs_oe;
   logic [7:0] kcol_o, pdo;
   wire [6:0] sel_v = {brom, p1, p2, p12, s1, s2, s3};
   wire [4:0] dr_v = {row_n, mux, cola, colb, we_n};

   sgd_glue dut_u (.core_clk_i(clk), .reset_i(rst), .ce_i(ce),
      .host_i(host), .slot_map_i(smap), .subslot_map_i(ssub),
      .wait_req_o(wait_q), .wait_req_oe_o(wait_oe),
      .ram_row_strobe_n_o(row_n), .dram_addr_mux_o(mux),
      .dram_col_strobe_a_n_o(cola), .dram_col_strobe_b_n_o(colb),
      .dram_write_en_n_o(we_n), .basic_rom_sel_n_o(brom),
      .rom_page1_sel_n_o(p1), .rom_page2_sel_n_o(p2),
      .rom_both_pages_sel_n_o(p12), .slot1_sel_n_o(s1),
      .slot2_sel_n_o(s2), .slot3_sel_n_o(s3), .joy_a_i(pin_a),
      .joy_b_i(pin_b), .joy_a_button_drive_i(bda),
      .joy_b_button_drive_i(bdb), .joy_a_pulse_i(pa), .joy_b_pulse_i(pb),
      .joy_a_o(ja), .joy_b_o(jb), .joy_a_button_o(bo_a),
      .joy_a_button_oe_o(boe_a), .joy_b_button_o(bo_b),
      .joy_b_button_oe_o(boe_b), .joy_a_pulse_out_o(pao),
      .joy_b_pulse_out_o(pbo), .kbd_row_sel_i(rsel),
      .kbd_row_scan_n_o(rs_n), .kbd_row_scan_oe_o(rs_oe),
      .kbd_column_in_n_i(kcol), .kbd_column_n_o(kcol_o),
      .kbd_func_sel_o(fsel), .kbd_layout_sel_i(layout),
      .kbd_layout_sel_o(lay_o), .capslock_lamp_i(lamp_c),
      .code_lamp_i(lamp_k), .capslock_lamp_n_o(cl_n),
      .capslock_lamp_oe_o(cl_oe), .code_lamp_n_o(cd_n),
      .code_lamp_oe_o(cd_oe), .printer_data_i(pdata),
      .printer_strobe_i(printer_strobe_n), .printer_busy_n_i(busy_n),
      .printer_data_out_o(pdo), .printer_strobe_n_o(printer_strobe_n_n),
      .printer_busy_o(busy_o));

   sgd_far_model far_u (.core_clk_i(clk), .btn_oe_a_i(boe_a),
      .btn_oe_b_i(boe_b), .btn_ext_a_i(exa), .btn_ext_b_i(exb),
      .dir_i(dirs), .busy_i(busy), .host_o(host), .joy_a_o(pin_a),
      .joy_b_o(pin_b), .busy_n_o(busy_n));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Galois shift register; keeps runs repeatable from one seed.
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
      return seed;
   endfunction

   // Ends one time step after the edge so all updates have landed.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // One memory cycle held 40 clocks; the model predicts every strobe.
   task automatic mem_cycle(input logic [8:0] a, input logic fetch,
                            input logic wr, input logic rf);
      int pg, sl, sb, n;
      logic ha, hb;
      logic [6:0] es;
      logic [4:0] e7;
      pg = int'(a[8:7]);
      sl = int'(smap[2*pg +: 2]);
      sb = int'(ssub[2*pg +: 2]);
      ha = !rf && sl == 0 && pg == 3;
      hb = !rf && sl == 3 && sb == 2;
      es = rf ? 7'h7F : {sl != 0 || pg > 1, pg != 1, pg != 2,
                         pg != 1 && pg != 2, sl != 1, sl != 2, sl != 3};
      e7 = {!(ha || hb || rf), ha || hb, !ha, !(hb && !ha),
            !((ha || hb) && wr)};
      n = 0;
      far_u.start(a, fetch, wr, rf);
      for (int i = 1; i <= 40; i++) begin
         tick(1);
         n += int'(wait_oe === 1'b1);
         if (i == 3) begin
            cmp(sel_v, es, "selects");
            cmp(dr_v, {!(ha || hb || rf), 4'h7}, "row");
         end
         if (i == 7) cmp(dr_v, e7, "dram");
      end
      cmp(16'(n), fetch ? 16'(sgd_pkg::WAIT_CYC) : 16'h0, "wait");
      cmp(wait_q, 1'b0, "wait level");
      far_u.finish();
      tick(4);
      cmp({sel_v, dr_v}, {7'h7F, 5'h17}, "release");
   endtask

   // Random pin traffic; row select walks every code 0 to 15.
   task automatic pin_test();
      logic [31:0] r;
      for (int k = 0; k < 24; k++) begin
         r = rnd();
         {kcol, pdata, dirs} = r[23:0];
         r = rnd();
         {bda, bdb, exa, exb, pa, pb, lamp_c, lamp_k, layout, printer_strobe_n, busy}
            = r[14:0];
         rsel = 4'(k);
         tick(4);
         cmp({ja, jb}, {dirs[7:4], ~(bda | exa), dirs[3:0],
             ~(bdb | exb)}, "joy");
         cmp({boe_a, boe_b, bo_a, bo_b, pao, pbo},
             {bda, bdb, 4'h0, pa, pb}, "buttons");
         cmp(rs_oe, rsel < 4'hA ? 10'h1 << rsel : 10'h0, "row oe");
         cmp(rs_n, 10'h0, "row level");
         cmp({kcol_o, lay_o, fsel}, {kcol, layout, 1'b0}, "kbd");
         cmp({cl_oe, cd_oe, cl_n, cd_n}, {lamp_c, lamp_k, 2'h0}, "lamps");
         cmp({pdo, printer_strobe_n_n, busy_o}, {pdata, !printer_strobe_n, busy}, "printer");
      end
      // A low clock enable must freeze every flop; row 7 is still driven.
      ce = 1'b0;
      pdata = ~pdata;
      rsel = 4'h3;
      tick(4);
      cmp({pdo, rs_oe[7:0]}, {~pdata, 8'h80}, "frozen");
      ce = 1'b1;
      tick(2);
      cmp({pdo, rs_oe[7:0]}, {pdata, 8'h08}, "thawed");
   endtask

   // Main sequence: reset, decode sweep, refresh, then the side pins.
   initial begin
      logic [31:0] r;
      rst = 1'b1;
      ce = 1'b1;
      smap = 8'h00;
      ssub = 8'h00;
      kcol = 8'hBF;
      {pdata, dirs, bda, bdb, exa, exb, rsel} = '0;
      {pa, pb, lamp_c, lamp_k, printer_strobe_n, busy} = '0;
      layout = 1'b1;
      tick(8);
      rst = 1'b0;
      tick(4);
      cmp({sel_v, dr_v, wait_oe, fsel}, {7'h7F, 5'h17, 2'h0}, "reset");
      $display("test reset done");
      // First half random maps, second half every slot against every page.
      for (int k = 0; k < 32; k++) begin
         r = rnd();
         smap = k[4] ? {4{k[1:0]}} : r[7:0];
         ssub = k[4] ? 8'hAA : r[15:8];
         mem_cycle({k[3:2], r[22:16]}, r[23] & ~(k[0] ^ k[2]),
                   k[0] ^ k[2], 1'b0);
      end
      $display("test decode done");
      repeat (2) mem_cycle(9'(rnd()), 1'b0, 1'b0, 1'b1);
      $display("test refresh done");
      pin_test();
      $display("test pins done");
      end_of_test();
   end

endmodule
`default_nettype wire
